// ==== rtl/gpio_port_irq_pad.sv ====
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module gpio_port_irq_pad (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [gpio_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [gpio_irq_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [gpio_irq_pkg::NUM_PINS-1:0] pin_in,
   input wire logic [gpio_irq_pkg::NUM_PINS-1:0] pin_dir_out,
   output logic irq,
   output logic [gpio_irq_pkg::NUM_PINS-1:0] pin_irq,
   output logic [gpio_irq_pkg::NUM_PINS-1:0] pad_pullup_en,
   output logic [gpio_irq_pkg::NUM_PINS-1:0] pad_pulldown_en,
   output logic [gpio_irq_pkg::NUM_PINS-1:0] pad_open_drain,
   output logic [2*gpio_irq_pkg::NUM_PINS-1:0] pad_drive_sel,
   output logic [gpio_irq_pkg::NUM_PINS-1:0] pad_slew_limit
);
   localparam int N = gpio_irq_pkg::NUM_PINS;
   localparam int AW = gpio_irq_pkg::ADDR_W;

   // Bus state
   logic aw_full_reg, aw_full_next;
   logic [AW-1:0] aw_addr_reg, aw_addr_next;
   logic w_full_reg, w_full_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;

   // Block state
   logic [N-1:0] raw_reg, raw_next;
   logic [N-1:0] enable_reg, enable_next;
   logic masked_status_select_reg, masked_status_select_next;
   logic [2:0] pin_sel_reg, pin_sel_next;
   logic [N-1:0][2:0] type_reg, type_next;
   logic [N-1:0] discrete_reg, discrete_next;
   logic [N-1:0][1:0] strength_reg, strength_next;
   logic [N-1:0][1:0] pintype_reg, pintype_next;

   // Output state
   logic irq_reg, irq_next;
   logic [N-1:0] pin_irq_reg, pin_irq_next;
   logic [N-1:0] pullup_reg, pullup_next;
   logic [N-1:0] pulldown_reg, pulldown_next;
   logic [N-1:0] od_reg, od_next;
   logic [2*N-1:0] drive_reg, drive_next;
   logic [N-1:0] slew_reg, slew_next;

   logic [N-1:0] event_hit;
   logic [N-1:0] masked;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic wr_fire;
   logic rd_fire;

   function automatic logic mapped(input logic [AW-1:0] a);
      case (a)
         gpio_irq_pkg::OFF_RAW, gpio_irq_pkg::OFF_MASKED,
         gpio_irq_pkg::OFF_STATUS, gpio_irq_pkg::OFF_STATUS_SEL,
         gpio_irq_pkg::OFF_ENABLE, gpio_irq_pkg::OFF_TYPE_SET,
         gpio_irq_pkg::OFF_PIN_SEL, gpio_irq_pkg::OFF_TYPE_GET,
         gpio_irq_pkg::OFF_PAD_SET, gpio_irq_pkg::OFF_PAD_GET: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_pin
         gpio_pin_detect u_detect (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .pin_async(pin_in[gi]),
            .detect_type(type_reg[gi]),
            .event_hit(event_hit[gi])
         );
      end
   endgenerate

   assign masked = raw_reg & enable_reg;

   // Bus handshakes
   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready = !w_full_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                   {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign wval = w_data_reg & wmask;

   always_comb begin
      aw_full_next = aw_full_reg;
      aw_addr_next = aw_addr_reg;
      w_full_next = w_full_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_next = 1'b1;
         w_data_next = s_axi_wdata;
         w_strb_next = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = mapped(aw_addr_reg) ? gpio_irq_pkg::RESP_OKAY :
                      gpio_irq_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rd_fire) begin
         rvalid_next = 1'b1;
         rdata_next = 32'h0000_0000;
         rresp_next = gpio_irq_pkg::RESP_OKAY;
         case (s_axi_araddr)
            gpio_irq_pkg::OFF_RAW: rdata_next[N-1:0] = raw_reg;
            gpio_irq_pkg::OFF_MASKED: rdata_next[N-1:0] = masked;
            gpio_irq_pkg::OFF_STATUS:
               rdata_next[N-1:0] = masked_status_select_reg ?
                                   masked : raw_reg;
            gpio_irq_pkg::OFF_STATUS_SEL:
               rdata_next[gpio_irq_pkg::SELECT_BIT] = masked_status_select_reg;
            gpio_irq_pkg::OFF_ENABLE: rdata_next[N-1:0] = enable_reg;
            gpio_irq_pkg::OFF_TYPE_SET: rdata_next = 32'h0000_0000;
            gpio_irq_pkg::OFF_PIN_SEL:
               rdata_next[gpio_irq_pkg::PIN_SEL_LSB +: 3] = pin_sel_reg;
            gpio_irq_pkg::OFF_TYPE_GET: begin
               rdata_next[gpio_irq_pkg::TYPE_LSB +: 3] =
                  type_reg[pin_sel_reg];
               rdata_next[gpio_irq_pkg::DISCRETE_BIT] =
                  discrete_reg[pin_sel_reg];
            end
            gpio_irq_pkg::OFF_PAD_SET: rdata_next = 32'h0000_0000;
            gpio_irq_pkg::OFF_PAD_GET: begin
               rdata_next[gpio_irq_pkg::STRENGTH_LSB +: 2] =
                  strength_reg[pin_sel_reg];
               rdata_next[gpio_irq_pkg::PINTYPE_LSB +: 2] =
                  pintype_reg[pin_sel_reg];
            end
            default: rresp_next = gpio_irq_pkg::RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // Register writes and sticky flags
   always_comb begin
      logic [N-1:0] clr;
      logic [N-1:0] pins;
      clr = '0;
      pins = '0;
      enable_next = enable_reg;
      masked_status_select_next = masked_status_select_reg;
      pin_sel_next = pin_sel_reg;
      type_next = type_reg;
      discrete_next = discrete_reg;
      strength_next = strength_reg;
      pintype_next = pintype_reg;
      if (wr_fire) begin
         pins = wval[gpio_irq_pkg::PINS_LSB +: N];
         case (aw_addr_reg)
            gpio_irq_pkg::OFF_STATUS: clr = pins;
            gpio_irq_pkg::OFF_RAW: clr = pins;
            gpio_irq_pkg::OFF_STATUS_SEL:
               if (w_strb_reg[0]) begin
                  masked_status_select_next =
                     w_data_reg[gpio_irq_pkg::SELECT_BIT];
               end
            gpio_irq_pkg::OFF_ENABLE:
               enable_next = (enable_reg & ~wmask[N-1:0]) |
                             wval[N-1:0];
            gpio_irq_pkg::OFF_PIN_SEL:
               if (w_strb_reg[0]) begin
                  pin_sel_next = w_data_reg[gpio_irq_pkg::PIN_SEL_LSB +: 3];
               end
            gpio_irq_pkg::OFF_TYPE_SET:
               if (w_strb_reg[1]) begin
                  for (int i = 0; i < N; i++) begin
                     if (pins[i]) begin
                        type_next[i] =
                           w_data_reg[gpio_irq_pkg::TYPE_LSB +: 3];
                        discrete_next[i] =
                           w_data_reg[gpio_irq_pkg::DISCRETE_BIT];
                     end
                  end
               end
            gpio_irq_pkg::OFF_PAD_SET:
               for (int i = 0; i < N; i++) begin
                  if (pins[i] && w_strb_reg[2]) begin
                     strength_next[i] =
                        w_data_reg[gpio_irq_pkg::STRENGTH_LSB +: 2];
                  end
                  if (pins[i] && w_strb_reg[3]) begin
                     pintype_next[i] =
                        w_data_reg[gpio_irq_pkg::PINTYPE_LSB +: 2];
                  end
               end
            default: clr = '0;
         endcase
      end
      // A new event in the clearing cycle keeps its flag
      raw_next = (raw_reg & ~clr) | event_hit;
   end

   // Outputs, registered from the state above
   always_comb begin
      logic [N-1:0] m_next;
      m_next = raw_next & enable_next;
      irq_next = |(m_next & ~discrete_next);
      pin_irq_next = m_next & discrete_next;
      for (int i = 0; i < N; i++) begin
         pullup_next[i] =
            (pintype_reg[i] == gpio_irq_pkg::PUSH_PULL_PULLUP_TYPE);
         pulldown_next[i] =
            (pintype_reg[i] == gpio_irq_pkg::PUSH_PULL_PULLDOWN_TYPE);
         // Input pins take only the termination setting
         od_next[i] = pin_dir_out[i] &&
            (pintype_reg[i] == gpio_irq_pkg::OPEN_DRAIN_TYPE);
         drive_next[2*i +: 2] = pin_dir_out[i] ? strength_reg[i] :
                                gpio_irq_pkg::DRIVE_LOW;
         slew_next[i] = pin_dir_out[i] && (strength_reg[i] ==
            gpio_irq_pkg::DRIVE_HIGH_SLEW_LIMITED);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= gpio_irq_pkg::RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= gpio_irq_pkg::RESP_OKAY;
         raw_reg <= '0;
         enable_reg <= gpio_irq_pkg::ENABLE_RST;
         masked_status_select_reg <= 1'b0;
         pin_sel_reg <= 3'h0;
         type_reg <= {N{gpio_irq_pkg::TYPE_RST}};
         discrete_reg <= '0;
         strength_reg <= {N{gpio_irq_pkg::STRENGTH_RST}};
         pintype_reg <= {N{gpio_irq_pkg::PINTYPE_RST}};
         irq_reg <= 1'b0;
         pin_irq_reg <= '0;
         pullup_reg <= '0;
         pulldown_reg <= '0;
         od_reg <= '0;
         drive_reg <= '0;
         slew_reg <= '0;
      end else begin
         aw_full_reg <= aw_full_next;
         aw_addr_reg <= aw_addr_next;
         w_full_reg <= w_full_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         raw_reg <= raw_next;
         enable_reg <= enable_next;
         masked_status_select_reg <= masked_status_select_next;
         pin_sel_reg <= pin_sel_next;
         type_reg <= type_next;
         discrete_reg <= discrete_next;
         strength_reg <= strength_next;
         pintype_reg <= pintype_next;
         irq_reg <= irq_next;
         pin_irq_reg <= pin_irq_next;
         pullup_reg <= pullup_next;
         pulldown_reg <= pulldown_next;
         od_reg <= od_next;
         drive_reg <= drive_next;
         slew_reg <= slew_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign irq = irq_reg;
   assign pin_irq = pin_irq_reg;
   assign pad_pullup_en = pullup_reg;
   assign pad_pulldown_en = pulldown_reg;
   assign pad_open_drain = od_reg;
   assign pad_drive_sel = drive_reg;
   assign pad_slew_limit = slew_reg;
endmodule

// ==== rtl/gpio_irq_pkg.sv ====
package gpio_irq_pkg;
   localparam int NUM_PINS = 8;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [5:0] OFF_RAW = 6'h00;
   localparam logic [5:0] OFF_MASKED = 6'h04;
   localparam logic [5:0] OFF_STATUS = 6'h08;
   localparam logic [5:0] OFF_STATUS_SEL = 6'h0C;
   localparam logic [5:0] OFF_ENABLE = 6'h10;
   localparam logic [5:0] OFF_TYPE_SET = 6'h14;
   localparam logic [5:0] OFF_PIN_SEL = 6'h18;
   localparam logic [5:0] OFF_TYPE_GET = 6'h1C;
   localparam logic [5:0] OFF_PAD_SET = 6'h20;
   localparam logic [5:0] OFF_PAD_GET = 6'h24;

   // Field positions, shared by the set and get words
   localparam int PINS_LSB = 0;
   localparam int TYPE_LSB = 8;
   localparam int DISCRETE_BIT = 11;
   localparam int STRENGTH_LSB = 16;
   localparam int PINTYPE_LSB = 24;
   localparam int SELECT_BIT = 0;
   localparam int PIN_SEL_LSB = 0;

   // Detection types
   localparam logic [2:0] DETECT_FALLING = 3'h0;
   localparam logic [2:0] DETECT_RISING = 3'h1;
   localparam logic [2:0] DETECT_BOTH = 3'h2;
   localparam logic [2:0] DETECT_LOW = 3'h3;
   localparam logic [2:0] DETECT_HIGH = 3'h4;

   // Drive strength encodings
   localparam logic [1:0] DRIVE_LOW = 2'h0;
   localparam logic [1:0] DRIVE_MEDIUM = 2'h1;
   localparam logic [1:0] DRIVE_HIGH = 2'h2;
   localparam logic [1:0] DRIVE_HIGH_SLEW_LIMITED = 2'h3;

   // Pin type encodings
   localparam logic [1:0] PUSH_PULL_TYPE = 2'h0;
   localparam logic [1:0] PUSH_PULL_PULLUP_TYPE = 2'h1;
   localparam logic [1:0] PUSH_PULL_PULLDOWN_TYPE = 2'h2;
   localparam logic [1:0] OPEN_DRAIN_TYPE = 2'h3;

   // Reset values
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [2:0] TYPE_RST = DETECT_FALLING;
   localparam logic [1:0] STRENGTH_RST = DRIVE_LOW;
   localparam logic [1:0] PINTYPE_RST = PUSH_PULL_TYPE;

   // Detector waits this many samples before trusting the history
   localparam logic [1:0] ARM_CYCLES = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/gpio_pin_detect.sv ====
`timescale 1ns/1ps
module gpio_pin_detect (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic pin_async,
   input wire logic [2:0] detect_type,
   output logic event_hit
);
   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic prev_reg, prev_next;
   logic [1:0] armed_reg, armed_next;
   logic armed;
   logic rise, fall;

   always_comb begin
      sync1_next = pin_async;
      sync2_next = sync1_reg;
      prev_next = sync2_reg;
      armed_next = armed_reg;
      if (armed_reg != gpio_irq_pkg::ARM_CYCLES) begin
         armed_next = armed_reg + 2'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
         armed_reg <= 2'h0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
         armed_reg <= armed_next;
      end
   end

   // No edges until the sync chain holds real pin samples
   assign armed = (armed_reg == gpio_irq_pkg::ARM_CYCLES);
   assign rise = armed & sync2_reg & ~prev_reg;
   assign fall = armed & ~sync2_reg & prev_reg;

   always_comb begin
      case (detect_type)
         gpio_irq_pkg::DETECT_FALLING: event_hit = fall;
         gpio_irq_pkg::DETECT_RISING: event_hit = rise;
         gpio_irq_pkg::DETECT_BOTH: event_hit = rise | fall;
         gpio_irq_pkg::DETECT_LOW: event_hit = armed & ~sync2_reg;
         gpio_irq_pkg::DETECT_HIGH: event_hit = armed & sync2_reg;
         default: event_hit = 1'b0;
      endcase
   end
endmodule

// ==== bench/gpio_irq_pad_checker_asserts.sv ====
`timescale 1ns/1ps
module gpio_irq_pad_checker (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] pin_dir_out,
   input wire logic irq,
   input wire logic [7:0] pin_irq,
   input wire logic [7:0] pad_pullup_en,
   input wire logic [7:0] pad_pulldown_en,
   input wire logic [7:0] pad_open_drain,
   input wire logic [15:0] pad_drive_sel,
   input wire logic [7:0] pad_slew_limit
);
   logic [7:0] drv_on;
   logic [7:0] slew_exp;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         drv_on[i] = |pad_drive_sel[2*i +: 2];
         slew_exp[i] = &pad_drive_sel[2*i +: 2];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_pull_excl: assert property (
      (pad_pullup_en & pad_pulldown_en) == 8'h00)
      else $error("pull-up and pull-down both on");
   a_od_needs_out: assert property (
      (pad_open_drain & ~$past(pin_dir_out)) == 8'h00)
      else $error("open drain on an input pin");
   a_drive_needs_out: assert property (
      (drv_on & ~$past(pin_dir_out)) == 8'h00)
      else $error("drive select on an input pin");
   a_slew_drive: assert property (
      pad_slew_limit == slew_exp)
      else $error("slew limit differs from drive select");
   a_irq_needs_write: assert property (
      $fell(irq) |-> s_axi_bvalid)
      else $error("irq fell without a register write");
   a_pin_irq_write: assert property (
      ($past(pin_irq) & ~pin_irq) != 8'h00 |-> s_axi_bvalid)
      else $error("pin irq fell without a register write");
   a_write_resp:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=>
         s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_ar_ready:
      assert property (s_axi_arready == !s_axi_rvalid)
      else $error("arready wrong");
endmodule

// ==== bench/irq_ctrl_model.sv ====
`timescale 1ns/1ps
module irq_ctrl_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic irq,
   input wire logic ack,
   output logic pend
);
   // Level sensitive: a source still high after ack pends again
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pend <= 1'b0;
      end else begin
         pend <= ack ? 1'b0 : (pend | irq);
      end
   end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic clk_sys, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq, ack, pend;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, r, seed;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] pin_in, pin_dir_out, pin_irq, pad_pullup_en;
   logic [7:0] pad_pulldown_en, pad_open_drain, pad_slew_limit;
   logic [15:0] pad_drive_sel, edv;
   logic [7:0] m_raw, m_en, v0, v1, msk, lvl, eu, ed, eo, es;
   logic [1:0] st[8], pt[8];
   int n_errors = 0;
   int comparisons = 0;
   int t, k, p;

   gpio_port_irq_pad u_dut (.clk_sys, .reset_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
      .pin_dir_out, .irq, .pin_irq, .pad_pullup_en, .pad_pulldown_en,
      .pad_open_drain, .pad_drive_sel, .pad_slew_limit);
   irq_ctrl_model u_host (.clk_sys, .reset_n, .irq, .ack, .pend);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic tally_and_finish();
      if (n_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic done(input bit got);
      chk("handshake", 32'(got), 32'h1);
      if (!got) tally_and_finish();
   endtask

   // Response ready is raised late at random to exercise holding
   task automatic wr(input logic [5:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [1:0] er = 2'h0);
      int n;
      int dly;
      bit got;
      dly = rnd() % 3;
      got = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            got = 1;
            s_axi_bready <= 1'b0;
            chk("bresp", 32'(s_axi_bresp), 32'(er));
         end else if (n == dly) begin
            s_axi_bready <= 1'b1;
         end
      end
      done(got);
   endtask

   task automatic rc(input logic [5:0] a, input logic [31:0] e,
         input logic [1:0] er = 2'h0);
      int n;
      int dly;
      bit got;
      dly = rnd() % 3;
      got = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            got = 1;
            s_axi_rready <= 1'b0;
            chk($sformatf("rdata %h", a), s_axi_rdata, e);
            chk("rresp", 32'(s_axi_rresp), 32'(er));
         end else if (n == dly) begin
            s_axi_rready <= 1'b1;
         end
      end
      done(got);
   endtask

   initial begin
      seed = 32'hCE4C;
      reset_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, ack} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, s_axi_wstrb, pin_in, pin_dir_out} = '0;
      for (k = 0; k < 8; k++) {st[k], pt[k]} = 4'h0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (k = 0; k <= 40; k += 4) rc(6'(k), 32'h0, k == 40 ? 2'h2 : 2'h0);
      wr(6'h3C, 32'hFF, 4'hF, gpio_irq_pkg::RESP_SLVERR);
      wr(gpio_irq_pkg::OFF_ENABLE, 32'hFF, 4'h0);
      rc(gpio_irq_pkg::OFF_ENABLE, 32'h0);
      for (k = 0; k < 16; k++) begin
         r = rnd();
         msk = r[7:0];
         pin_dir_out <= r[15:8];
         p = int'(r[18:16]);
         wr(gpio_irq_pkg::OFF_PAD_SET,
            {6'h0, k[1:0], 6'h0, k[3:2], 8'h0, msk}, 4'hF);
         for (int i = 0; i < 8; i++) begin
            if (msk[i]) {st[i], pt[i]} = {k[3:2], k[1:0]};
            eu[i] = pt[i] == 2'h1;
            ed[i] = pt[i] == 2'h2;
            eo[i] = pt[i] == 2'h3 && r[8+i];
            edv[2*i +: 2] = r[8+i] ? st[i] : 2'h0;
            es[i] = st[i] == 2'h3 && r[8+i];
         end
         wr(gpio_irq_pkg::OFF_PIN_SEL, 32'(p), 4'h1);
         rc(gpio_irq_pkg::OFF_PAD_GET,
            {6'h0, pt[p], 6'h0, st[p], 16'h0});
         chk("pullup", 32'(pad_pullup_en), 32'(eu));
         chk("pulldown", 32'(pad_pulldown_en), 32'(ed));
         chk("open_drain", 32'(pad_open_drain), 32'(eo));
         chk("drive", 32'(pad_drive_sel), 32'(edv));
         chk("slew", 32'(pad_slew_limit), 32'(es));
      end
      for (t = 0; t < 6; t++) begin
         r = rnd();
         {msk, m_en, v1, v0} = r;
         pin_in <= v0;
         repeat (5) @(posedge clk_sys);
         wr(gpio_irq_pkg::OFF_TYPE_SET, {20'h0, 1'b1, t[2:0], 8'hF0}, 4'h3);
         wr(gpio_irq_pkg::OFF_TYPE_SET, {20'h0, 1'b0, t[2:0], 8'h0F}, 4'h3);
         wr(gpio_irq_pkg::OFF_ENABLE, 32'(m_en), 4'h1);
         wr(gpio_irq_pkg::OFF_STATUS, 32'hFF, 4'h1);
         pin_in <= v1;
         repeat (6) @(posedge clk_sys);
         case (t)
            0: m_raw = v0 & ~v1;
            1: m_raw = ~v0 & v1;
            2: m_raw = v0 ^ v1;
            3: m_raw = ~v0 | ~v1;
            4: m_raw = v0 | v1;
            default: m_raw = 8'h00;
         endcase
         lvl = (t == 3) ? ~v1 : (t == 4) ? v1 : 8'h00;
         rc(gpio_irq_pkg::OFF_RAW, 32'(m_raw));
         rc(gpio_irq_pkg::OFF_MASKED, 32'(m_raw & m_en));
         wr(gpio_irq_pkg::OFF_STATUS_SEL, 32'(t[0]), 4'h1);
         rc(gpio_irq_pkg::OFF_STATUS,
            32'(t[0] ? m_raw & m_en : m_raw));
         chk("irq", 32'(irq), 32'(|(m_raw & m_en & 8'h0F)));
         chk("pin_irq", 32'(pin_irq), 32'(m_raw & m_en & 8'hF0));
         wr(gpio_irq_pkg::OFF_PIN_SEL, 32'(t % 8), 4'h1);
         rc(gpio_irq_pkg::OFF_TYPE_GET,
            {20'h0, t >= 4, t[2:0], 8'h0});
         wr(t[0] ? gpio_irq_pkg::OFF_RAW : gpio_irq_pkg::OFF_STATUS,
            32'(msk), 4'h1);
         m_raw = (m_raw & ~msk) | lvl;
         rc(gpio_irq_pkg::OFF_RAW, 32'(m_raw));
         // Handler clears first, acknowledges after
         wr(gpio_irq_pkg::OFF_STATUS, 32'hFF, 4'h1);
         @(posedge clk_sys);
         ack <= 1'b1;
         @(posedge clk_sys);
         ack <= 1'b0;
         repeat (2) @(posedge clk_sys);
         chk("pend", 32'(pend), 32'(|(lvl & m_en & 8'h0F)));
      end
      tally_and_finish();
   end
endmodule

bind gpio_port_irq_pad gpio_irq_pad_checker u_chk (.clk_sys, .reset_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_dir_out, .irq,
   .pin_irq, .pad_pullup_en, .pad_pulldown_en, .pad_open_drain,
   .pad_drive_sel, .pad_slew_limit);
